/* File: pkg/usbr_pkg.sv */
// Package with register map, field layout and state types of the serial port
package usbr_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_CONTROL   = 32'hf8040000;
  localparam logic [31:0] ADDR_MODE      = 32'hf8040004;
  localparam logic [31:0] ADDR_IRQ_EN    = 32'hf8040008;
  localparam logic [31:0] ADDR_IRQ_DIS   = 32'hf804000c;
  localparam logic [31:0] ADDR_IRQ_MASK  = 32'hf8040010;
  localparam logic [31:0] ADDR_STATUS    = 32'hf8040014;
  localparam logic [31:0] ADDR_RX_HOLD   = 32'hf8040018;
  localparam logic [31:0] ADDR_TX_HOLD   = 32'hf804001c;
  localparam logic [31:0] ADDR_BAUD      = 32'hf8040020;
  localparam logic [31:0] ADDR_EVENTS    = 32'hf8040040;

  // Shared flag layout of enable, disable, mask, status and event words
  localparam int BIT_RX_AVAIL  = 0;
  localparam int BIT_TX_FREE   = 1;
  localparam int BIT_OVERRUN   = 5;
  localparam int BIT_FRAMING   = 6;
  localparam int BIT_PARITY    = 7;
  localparam int BIT_TX_DONE   = 9;

  // Control word command bits
  localparam int CTL_RX_RESET  = 2;
  localparam int CTL_TX_RESET  = 3;
  localparam int CTL_RX_EN     = 4;
  localparam int CTL_RX_DIS    = 5;
  localparam int CTL_TX_EN     = 6;
  localparam int CTL_TX_DIS    = 7;
  localparam int CTL_CLR_ERR   = 8;

  // Mode word fields
  localparam int MODE_PAR_LSB  = 9;
  localparam int MODE_CH_LSB   = 14;
  localparam logic [31:0] MODE_WR_MASK = 32'h0000ce00;

  // Reset values
  localparam logic [31:0] MODE_RESET = 32'h00000000;
  localparam logic [15:0] BAUD_RESET = 16'h0000;

  // Oversampling: last of sixteen ticks per bit and the mid-bit sample point
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_MID  = 4'h7;

  // Parity kinds
  localparam logic [2:0] PAR_EVEN  = 3'h0;
  localparam logic [2:0] PAR_ODD   = 3'h1;
  localparam logic [2:0] PAR_SPACE = 3'h2;
  localparam logic [2:0] PAR_MARK  = 3'h3;

  // Channel modes
  localparam logic [1:0] CH_NORMAL = 2'h0;
  localparam logic [1:0] CH_ECHO   = 2'h1;
  localparam logic [1:0] CH_LOCAL  = 2'h2;
  localparam logic [1:0] CH_REMOTE = 2'h3;

  // Flag group carried as one unit
  typedef struct packed {
    logic tx_all_done;
    logic parity_error_flag;
    logic framing_error_flag;
    logic overrun_flag;
    logic tx_holding_free;
    logic rx_char_available;
  } usbr_flags_t;

  // Frame sequencer states, one-hot
  typedef enum logic [4:0] {
    FR_IDLE  = 5'h01,
    FR_START = 5'h02,
    FR_DATA  = 5'h04,
    FR_PAR   = 5'h08,
    FR_STOP  = 5'h10
  } usbr_frame_t;

endpackage

/* File: core/usbr_uart.sv */
// Serial port with status, interrupt mask, holding and baud registers
//
// Overview of operation
// - Disable write of one clears mask bit
// - Mask read shows one per enabled source
// - Disable, mask, status share one bit layout
// - Received-char flag set on load, cleared on read
// - Holding-free low while char pending or disabled
// - Overrun flag sticky until error clear command
// - Framing flag sticky until error clear command
// - Parity flag sticky until error clear command
// - All-done high only when holding and shifter empty
// - Receive register holds last char in 7:0
// - Written char sent after current char completes
// - Divisor zero stops the baud clock
// - Baud equals master clock over sixteen times divisor
// - Error clear command clears three error flags
// - Enable write of one sets mask bit
// - Frame: start, eight data lsb first, parity unless mode bit 11 is set, stop
`timescale 1ns/1ps
module usbr_uart #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  // Interrupt
  output logic             irq
);

  // Flags onto the shared 32-bit layout
  function automatic logic [31:0] flags_to_word(usbr_pkg::usbr_flags_t f);
    logic [31:0] w;
    w = 32'h00000000;
    w[usbr_pkg::BIT_RX_AVAIL] = f.rx_char_available;
    w[usbr_pkg::BIT_TX_FREE]  = f.tx_holding_free;
    w[usbr_pkg::BIT_OVERRUN]  = f.overrun_flag;
    w[usbr_pkg::BIT_FRAMING]  = f.framing_error_flag;
    w[usbr_pkg::BIT_PARITY]   = f.parity_error_flag;
    w[usbr_pkg::BIT_TX_DONE]  = f.tx_all_done;
    return w;
  endfunction

  // Word in the shared layout back to flags
  function automatic usbr_pkg::usbr_flags_t word_to_flags(logic [31:0] w);
    usbr_pkg::usbr_flags_t f;
    f.rx_char_available  = w[usbr_pkg::BIT_RX_AVAIL];
    f.tx_holding_free    = w[usbr_pkg::BIT_TX_FREE];
    f.overrun_flag       = w[usbr_pkg::BIT_OVERRUN];
    f.framing_error_flag = w[usbr_pkg::BIT_FRAMING];
    f.parity_error_flag  = w[usbr_pkg::BIT_PARITY];
    f.tx_all_done        = w[usbr_pkg::BIT_TX_DONE];
    return f;
  endfunction

  // Expected parity bit; shared by transmitter and receiver
  function automatic logic parity_of(logic [7:0] d, logic [2:0] kind);
    case (kind)
      usbr_pkg::PAR_EVEN:  parity_of = ^d;
      usbr_pkg::PAR_ODD:   parity_of = ~(^d);
      usbr_pkg::PAR_SPACE: parity_of = 1'b0;
      usbr_pkg::PAR_MARK:  parity_of = 1'b1;
      default:             parity_of = 1'b1;
    endcase
  endfunction

  // Configuration and holding state
  logic [31:0]             mode_q;        // Parity and channel mode
  logic [DIV_W-1:0]        div_q;         // Baud divisor
  usbr_pkg::usbr_flags_t   mask_q;        // Interrupt mask
  usbr_pkg::usbr_flags_t   evt_q;         // Sticky event bits
  logic                    tx_en_q;       // Transmitter enabled
  logic                    rx_en_q;       // Receiver enabled
  logic [7:0]              thr_q;         // Transmit holding
  logic                    thr_full_q;    // Holding has a char
  logic [7:0]              rhr_q;         // Receive holding
  logic                    rx_avail_q;    // Char waiting to be read
  logic                    ovr_q;         // Sticky overrun
  logic                    frm_q;         // Sticky framing error
  logic                    par_q;         // Sticky parity error
  logic [31:0]             prdata_q;      // Captured read data

  // Baud divider state
  logic [DIV_W-1:0]        bcnt_q;
  logic                    tick;

  // Transmit sequencer
  usbr_pkg::usbr_frame_t   txs_q;
  logic [3:0]              tsub_q;        // Tick within bit
  logic [2:0]              tbit_q;        // Data bit index
  logic [7:0]              tsh_q;         // Shift register
  logic                    tline_q;       // Transmit line level

  // Receive sequencer
  usbr_pkg::usbr_frame_t   rxs_q;
  logic [3:0]              rsub_q;
  logic [2:0]              rbit_q;
  logic [7:0]              rsh_q;
  logic                    rpar_bad_q;    // Parity mismatch this char

  // APB decode
  wire logic wr_acc = psel & penable & pwrite;
  wire logic rd_acc = psel & penable & ~pwrite;
  wire logic setup  = psel & ~penable;
  wire logic hit_ctl  = paddr == usbr_pkg::ADDR_CONTROL;
  wire logic hit_mode = paddr == usbr_pkg::ADDR_MODE;
  wire logic hit_ien  = paddr == usbr_pkg::ADDR_IRQ_EN;
  wire logic hit_idis = paddr == usbr_pkg::ADDR_IRQ_DIS;
  wire logic hit_mask = paddr == usbr_pkg::ADDR_IRQ_MASK;
  wire logic hit_stat = paddr == usbr_pkg::ADDR_STATUS;
  wire logic hit_rhr  = paddr == usbr_pkg::ADDR_RX_HOLD;
  wire logic hit_thr  = paddr == usbr_pkg::ADDR_TX_HOLD;
  wire logic hit_baud = paddr == usbr_pkg::ADDR_BAUD;
  wire logic hit_evt  = paddr == usbr_pkg::ADDR_EVENTS;
  wire logic hit_any  = hit_ctl | hit_mode | hit_ien | hit_idis | hit_mask
                      | hit_stat | hit_rhr | hit_thr | hit_baud | hit_evt;

  // Write strobes and command bits
  wire logic wr_ctl  = wr_acc & hit_ctl;
  wire logic cmd_rx_reset = wr_ctl & pwdata[usbr_pkg::CTL_RX_RESET];
  wire logic cmd_tx_reset = wr_ctl & pwdata[usbr_pkg::CTL_TX_RESET];
  wire logic cmd_clr_err  = wr_ctl & pwdata[usbr_pkg::CTL_CLR_ERR];
  wire logic wr_thr  = wr_acc & hit_thr;
  wire logic rd_rhr  = rd_acc & hit_rhr;

  // Mode fields
  wire logic [2:0] par_kind = mode_q[usbr_pkg::MODE_PAR_LSB +: 3];
  wire logic [1:0] ch_mode  = mode_q[usbr_pkg::MODE_CH_LSB +: 2];
  wire logic       par_on   = ~par_kind[2];

  // Internal line into the receiver; local loopback feeds it from transmit
  wire logic rx_line = (ch_mode == usbr_pkg::CH_LOCAL) ? tline_q
                                                       : serial_in_pin;
  // Remote loopback disables both halves
  wire logic remote  = ch_mode == usbr_pkg::CH_REMOTE;

  // Current flags as seen by software
  usbr_pkg::usbr_flags_t stat;
  assign stat.rx_char_available  = rx_avail_q;
  assign stat.tx_holding_free    = tx_en_q & ~thr_full_q;
  assign stat.overrun_flag       = ovr_q;
  assign stat.framing_error_flag = frm_q;
  assign stat.parity_error_flag  = par_q;
  assign stat.tx_all_done        = tx_en_q & ~thr_full_q
                                 & (txs_q == usbr_pkg::FR_IDLE);

  // Read multiplexer; mask, status and event words in the shared layout
  wire logic [31:0] rd_word =
      hit_mask ? flags_to_word(mask_q) :
      hit_stat ? flags_to_word(stat) :
      hit_rhr  ? {24'h000000, rhr_q} :
      hit_mode ? mode_q :
      hit_baud ? {{(32-DIV_W){1'b0}}, div_q} :
      hit_evt  ? flags_to_word(evt_q) : 32'h00000000;

  // Zero wait states; data captured in setup, so it comes from a flop
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata  = prdata_q;
  assign irq     = |(flags_to_word(stat) & flags_to_word(mask_q));

  // Pin: echo and remote loopback repeat the input, local holds idle
  assign serial_out_pin = (ch_mode == usbr_pkg::CH_NORMAL) ? tline_q :
                          (ch_mode == usbr_pkg::CH_LOCAL)  ? 1'b1
                                                           : serial_in_pin;

  // Read data capture
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata_q <= 32'h00000000;
    end else if (setup) begin
      prdata_q <= rd_word;
    end
  end

  // Configuration writes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= usbr_pkg::MODE_RESET;
      div_q  <= DIV_W'(usbr_pkg::BAUD_RESET);
    end else begin
      if (wr_acc && hit_mode) begin
        mode_q <= pwdata & usbr_pkg::MODE_WR_MASK;
      end
      if (wr_acc && hit_baud) begin
        div_q <= pwdata[DIV_W-1:0];
      end
    end
  end

  // Mask: enable sets, disable clears, zeros leave bits alone
  wire logic [31:0] mask_w = flags_to_word(mask_q);
  wire logic [31:0] ien_w  = (wr_acc && hit_ien)  ? pwdata : 32'h00000000;
  wire logic [31:0] idis_w = (wr_acc && hit_idis) ? pwdata : 32'h00000000;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= '0;
    end else begin
      mask_q <= word_to_flags((mask_w | ien_w) & ~idis_w);
    end
  end

  // Sticky events: rising flags set, write one clears, set wins
  wire logic [31:0] stat_w = flags_to_word(stat);
  logic [31:0]      stat_prev_q;
  wire logic [31:0] evt_clr = (wr_acc && hit_evt) ? pwdata : 32'h00000000;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stat_prev_q <= 32'h00000000;
      evt_q       <= '0;
    end else begin
      stat_prev_q <= stat_w;
      evt_q <= word_to_flags((flags_to_word(evt_q) & ~evt_clr)
                             | (stat_w & ~stat_prev_q));
    end
  end

  // Enables; reset commands also disable, disable beats enable
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_en_q <= 1'b0;
      rx_en_q <= 1'b0;
    end else if (wr_ctl) begin
      if (pwdata[usbr_pkg::CTL_TX_DIS] || pwdata[usbr_pkg::CTL_TX_RESET]) begin
        tx_en_q <= 1'b0;
      end else if (pwdata[usbr_pkg::CTL_TX_EN]) begin
        tx_en_q <= 1'b1;
      end
      if (pwdata[usbr_pkg::CTL_RX_DIS] || pwdata[usbr_pkg::CTL_RX_RESET]) begin
        rx_en_q <= 1'b0;
      end else if (pwdata[usbr_pkg::CTL_RX_EN]) begin
        rx_en_q <= 1'b1;
      end
    end
  end

  // Baud divider: one oversample tick every divisor cycles
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bcnt_q <= '0;
    end else if (div_q == '0) begin
      bcnt_q <= '0;
    end else if (bcnt_q >= div_q - DIV_W'(1)) begin
      bcnt_q <= '0;
    end else begin
      bcnt_q <= bcnt_q + DIV_W'(1);
    end
  end
  // Sixteen ticks per bit give clock over sixteen times divisor
  assign tick = (div_q != '0) && (bcnt_q >= div_q - DIV_W'(1));

  // Transmit holding: filled by software, drained by the shifter
  wire logic tx_load = tx_en_q & ~remote & thr_full_q
                     & (txs_q == usbr_pkg::FR_IDLE);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      thr_q      <= 8'h00;
      thr_full_q <= 1'b0;
    end else if (cmd_tx_reset) begin
      thr_full_q <= 1'b0;
    end else if (wr_thr) begin
      thr_q      <= pwdata[7:0];
      thr_full_q <= 1'b1;
    end else if (tx_load) begin
      thr_full_q <= 1'b0;
    end
  end

  // Transmit sequencer; next char waits for the stop bit to finish
  wire logic tx_bit_end = tick & (tsub_q == usbr_pkg::TICK_LAST);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      txs_q   <= usbr_pkg::FR_IDLE;
      tsub_q  <= 4'h0;
      tbit_q  <= 3'h0;
      tsh_q   <= 8'h00;
      tline_q <= 1'b1;
    end else if (cmd_tx_reset) begin
      txs_q   <= usbr_pkg::FR_IDLE;                // Abort at once
      tline_q <= 1'b1;
    end else begin
      if (tick) begin
        tsub_q <= tsub_q + 4'h1;
      end
      case (txs_q)
        usbr_pkg::FR_IDLE: begin
          tline_q <= 1'b1;
          if (tx_load) begin
            tsh_q   <= thr_q;
            tsub_q  <= 4'h0;
            tline_q <= 1'b0;
            txs_q   <= usbr_pkg::FR_START;
          end
        end
        usbr_pkg::FR_START: begin
          if (tx_bit_end) begin
            tline_q <= tsh_q[0];                   // Lsb first
            tbit_q  <= 3'h0;
            txs_q   <= usbr_pkg::FR_DATA;
          end
        end
        usbr_pkg::FR_DATA: begin
          if (tx_bit_end) begin
            if (tbit_q == 3'h7) begin
              tline_q <= par_on ? parity_of(tsh_q, par_kind) : 1'b1;
              txs_q   <= par_on ? usbr_pkg::FR_PAR : usbr_pkg::FR_STOP;
            end else begin
              tline_q <= tsh_q[tbit_q + 3'h1];
              tbit_q  <= tbit_q + 3'h1;
            end
          end
        end
        usbr_pkg::FR_PAR: begin
          if (tx_bit_end) begin
            tline_q <= 1'b1;
            txs_q   <= usbr_pkg::FR_STOP;
          end
        end
        usbr_pkg::FR_STOP: begin
          if (tx_bit_end) begin
            txs_q <= usbr_pkg::FR_IDLE;
          end
        end
        default: begin
          txs_q   <= usbr_pkg::FR_IDLE;
          tline_q <= 1'b1;
        end
      endcase
    end
  end

  // Receive sequencer; start is checked again at mid-bit to skip glitches
  wire logic rx_run     = rx_en_q & ~remote;
  wire logic rx_mid     = tick & (rsub_q == usbr_pkg::TICK_MID);
  wire logic rx_bit_end = tick & (rsub_q == usbr_pkg::TICK_LAST);
  wire logic rx_done    = (rxs_q == usbr_pkg::FR_STOP) & rx_bit_end;
  logic      stop_lo_q;   // Stop bit sampled low at mid-bit
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rxs_q      <= usbr_pkg::FR_IDLE;
      rsub_q     <= 4'h0;
      rbit_q     <= 3'h0;
      rsh_q      <= 8'h00;
      rpar_bad_q <= 1'b0;
      stop_lo_q  <= 1'b0;
    end else if (cmd_rx_reset || !rx_run) begin
      rxs_q <= usbr_pkg::FR_IDLE;                  // Abort or hold idle
    end else begin
      if (tick) begin
        rsub_q <= rsub_q + 4'h1;
      end
      case (rxs_q)
        usbr_pkg::FR_IDLE: begin
          if (tick && !rx_line) begin
            rsub_q     <= 4'h1;
            rpar_bad_q <= 1'b0;
            rxs_q      <= usbr_pkg::FR_START;
          end
        end
        usbr_pkg::FR_START: begin
          if (rx_mid && rx_line) begin
            rxs_q <= usbr_pkg::FR_IDLE;            // False start
          end else if (rx_bit_end) begin
            rbit_q <= 3'h0;
            rxs_q  <= usbr_pkg::FR_DATA;
          end
        end
        usbr_pkg::FR_DATA: begin
          if (rx_mid) begin
            rsh_q <= {rx_line, rsh_q[7:1]};        // Lsb arrives first
          end
          if (rx_bit_end) begin
            rbit_q <= rbit_q + 3'h1;
            if (rbit_q == 3'h7) begin
              rxs_q <= par_on ? usbr_pkg::FR_PAR : usbr_pkg::FR_STOP;
            end
          end
        end
        usbr_pkg::FR_PAR: begin
          if (rx_mid) begin
            rpar_bad_q <= rx_line != parity_of(rsh_q, par_kind);
          end
          if (rx_bit_end) begin
            rxs_q <= usbr_pkg::FR_STOP;
          end
        end
        usbr_pkg::FR_STOP: begin
          if (rx_mid) begin
            stop_lo_q <= ~rx_line;
          end
          if (rx_bit_end) begin
            rxs_q <= usbr_pkg::FR_IDLE;
          end
        end
        default: rxs_q <= usbr_pkg::FR_IDLE;
      endcase
    end
  end

  // Receive holding and flags; a new char beats a same-cycle read
  wire logic frm_now = rx_done & (stop_lo_q | ~rx_line);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rhr_q      <= 8'h00;
      rx_avail_q <= 1'b0;
      ovr_q      <= 1'b0;
      frm_q      <= 1'b0;
      par_q      <= 1'b0;
    end else begin
      if (rx_done) begin
        rhr_q      <= rsh_q;
        rx_avail_q <= 1'b1;
      end else if (rd_rhr || !rx_en_q) begin
        rx_avail_q <= 1'b0;
      end
      if (rx_done && rx_avail_q && !rd_rhr) begin
        ovr_q <= 1'b1;
      end else if (cmd_clr_err) begin
        ovr_q <= 1'b0;
      end
      if (frm_now) begin
        frm_q <= 1'b1;
      end else if (cmd_clr_err) begin
        frm_q <= 1'b0;
      end
      if (rx_done && par_on && rpar_bad_q) begin
        par_q <= 1'b1;
      end else if (cmd_clr_err) begin
        par_q <= 1'b0;
      end
    end
  end

endmodule

/* File: verif/usbr_uart_properties.sv */
// Checker of register and line behaviour seen at the port pins
`timescale 1ns/1ps
module usbr_uart_chk (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_b,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Line and interrupt
  input wire logic        serial_in_pin,
  input wire logic        serial_out_pin,
  input wire logic        irq
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Access-phase decodes
  wire         wr = psel & penable & pwrite;
  wire         rd = psel & penable & ~pwrite;
  wire [31:0]  a  = paddr;
  logic [31:0] mask_q, mask_d;   // Shadow of enabled sources
  logic [15:0] baud_q, baud_d;   // Shadow of the divisor
  logic        quiet_q, quiet_d; // No char written, mode untouched
  assign mask_d = !wr ? mask_q
    : a == usbr_pkg::ADDR_IRQ_EN ? mask_q | (pwdata & 32'h000002e3)
    : a == usbr_pkg::ADDR_IRQ_DIS ? mask_q & ~pwdata : mask_q;
  assign baud_d = (wr && a == usbr_pkg::ADDR_BAUD) ? pwdata[15:0] : baud_q;
  // Echo modes could drive the pin, so a mode write ends the quiet span
  assign quiet_d = quiet_q & ~(wr && (a == usbr_pkg::ADDR_TX_HOLD
    || a == usbr_pkg::ADDR_MODE));
  // Shadows follow writes at the edge where they take effect
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mask_q  <= '0;
      baud_q  <= '0;
      quiet_q <= 1'b1;
    end else begin
      mask_q  <= mask_d;
      baud_q  <= baud_d;
      quiet_q <= quiet_d;
    end
  end
  mask_read_a: assert property (
    rd && a == usbr_pkg::ADDR_IRQ_MASK |-> prdata == mask_q)
    else $error("mask read differs from enabled sources");
  dis_irq_a: assert property (
    wr && a == usbr_pkg::ADDR_IRQ_DIS && (pwdata & 32'h2e3) == 32'h2e3
    |=> !irq) else $error("irq stays after full disable");
  irq_off_a: assert property (mask_q == '0 |-> !irq)
    else $error("irq with no source enabled");
  status_rsvd_a: assert property (
    rd && a == usbr_pkg::ADDR_STATUS |-> (prdata & ~32'h2e3) == '0)
    else $error("reserved status bits set");
  done_free_a: assert property (
    rd && a == usbr_pkg::ADDR_STATUS && prdata[9] |-> prdata[1])
    else $error("all done while holding not free");
  rhr_rsvd_a: assert property (
    rd && a == usbr_pkg::ADDR_RX_HOLD |-> prdata[31:8] == '0)
    else $error("receive upper bits set");
  baud_read_a: assert property (
    rd && a == usbr_pkg::ADDR_BAUD |-> prdata == {16'h0000, baud_q})
    else $error("divisor read differs");
  line_idle_a: assert property (quiet_q |-> serial_out_pin)
    else $error("line left idle level");
  cover property (rd && a == usbr_pkg::ADDR_IRQ_MASK && prdata != '0);
  cover property ($rose(irq));
  cover property (rd && a == usbr_pkg::ADDR_STATUS && prdata[5]);
endmodule
bind usbr_uart usbr_uart_chk chk_u (.clk_sys(clk_sys), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
  .irq(irq));

/* File: verif/usbr_remote.sv */
// Remote serial device model on the far side of the line pins
`timescale 1ns/1ps
module usbr_remote (
  // Clock
  input  wire logic clk_sys,
  // Line
  input  wire logic serial_out_pin,
  output logic      serial_in_pin
);
  int         bit_clks = 16;   // Clocks per bit, set by the bench
  bit         listen   = 1'b1; // Capture frames only when set
  int         rx_count = 0;    // Frames captured
  logic [7:0] rx_byte;         // Data of the last frame
  logic       rx_stop;         // Level seen in its stop bit
  initial serial_in_pin = 1'b1;
  // Send one frame with even parity; flags corrupt parity or stop
  task automatic send(input logic [7:0] d, input logic pflip, stp);
    logic [10:0] f;
    f = {stp, ^d ^ pflip, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_sys);
      serial_in_pin <= f[i];
      repeat (bit_clks - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    serial_in_pin <= 1'b1;
  endtask
  // Capture frames mid-bit; parity bit is skipped, stop is kept
  always begin
    @(negedge serial_out_pin);
    if (listen) begin
      repeat (bit_clks / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_clks) @(posedge clk_sys);
        rx_byte[i] = serial_out_pin;
      end
      repeat (2 * bit_clks) @(posedge clk_sys);
      rx_stop = serial_out_pin;
      rx_count++;
    end
  end
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the serial port registers and line
`timescale 1ns/1ps
module tb;
  // Design pins
  logic        clk_sys, rst_b, psel, penable, pwrite, irq;
  logic [31:0] paddr, pwdata, prdata;
  logic        pready, pslverr, serial_in_pin, serial_out_pin;
  logic [31:0] rdat;       // Data of the last read
  logic        rerr;       // Error answer of the last access
  int          errors;     // Mismatches
  int          num_checks; // Comparisons made
  // Ordinary case: write flag, address, data, expected data and error
  typedef struct {logic w; logic [31:0] a, d, e; logic x;} usbr_row_t;
  usbr_row_t rows [13] = '{
    '{0, usbr_pkg::ADDR_IRQ_MASK, 0, 0, 0},
    '{0, usbr_pkg::ADDR_STATUS, 0, 0, 0},
    '{1, usbr_pkg::ADDR_BAUD, 32'h00012345, 0, 0},
    '{0, usbr_pkg::ADDR_BAUD, 0, 32'h00002345, 0},
    '{1, usbr_pkg::ADDR_IRQ_EN, 32'hffffffff, 0, 0},
    '{0, usbr_pkg::ADDR_IRQ_MASK, 0, 32'h000002e3, 0},
    '{1, usbr_pkg::ADDR_IRQ_DIS, 32'h00000021, 0, 0},
    '{0, usbr_pkg::ADDR_IRQ_MASK, 0, 32'h000002c2, 0},
    '{1, usbr_pkg::ADDR_IRQ_MASK, 32'hffffffff, 0, 0},
    '{0, usbr_pkg::ADDR_IRQ_MASK, 0, 32'h000002c2, 0},
    '{1, usbr_pkg::ADDR_IRQ_DIS, 32'hffffffff, 0, 0},
    '{0, usbr_pkg::ADDR_IRQ_MASK, 0, 0, 0},
    '{1, 32'hf8040030, 32'h1, 0, 1}};
  usbr_uart #(.DIV_W(16)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .irq(irq));
  usbr_remote rem_u (.clk_sys(clk_sys), .serial_out_pin(serial_out_pin),
    .serial_in_pin(serial_in_pin));
  // Free-running 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, request held until pready is seen high
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [31:0] a, e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // Bounded wait for the remote to capture n frames
  task automatic wait_rx(input int n);
    repeat (4000) if (rem_u.rx_count < n) @(posedge clk_sys);
    chk(rem_u.rx_count, n);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog far past the expected run
  initial begin
    #200000;
    errors++;
    wrap_up();
  end
  initial begin
    {rst_b, psel, penable, pwrite} = '0;
    {paddr, pwdata} = '0;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(rerr, rows[i].x);
      if (!rows[i].w) chk(rdat, rows[i].e);
    end
    apb(1, usbr_pkg::ADDR_BAUD, 32'h1);
    apb(1, usbr_pkg::ADDR_CONTROL, 32'h50);
    rchk(usbr_pkg::ADDR_STATUS, 32'h202);
    apb(1, usbr_pkg::ADDR_IRQ_EN, 32'h2);
    @(posedge clk_sys);
    chk(irq, 1);
    apb(1, usbr_pkg::ADDR_IRQ_DIS, 32'h2);
    @(posedge clk_sys);
    chk(irq, 0);
    // Back-to-back characters: the second waits in holding
    apb(1, usbr_pkg::ADDR_TX_HOLD, 32'ha5);
    apb(1, usbr_pkg::ADDR_TX_HOLD, 32'h3c);
    rchk(usbr_pkg::ADDR_STATUS, 32'h0);
    wait_rx(1);
    chk(rem_u.rx_byte, 8'ha5);
    wait_rx(2);
    chk(rem_u.rx_byte, 8'h3c);
    chk(rem_u.rx_stop, 1);
    repeat (40) @(posedge clk_sys);
    rchk(usbr_pkg::ADDR_STATUS, 32'h202);
    apb(1, usbr_pkg::ADDR_BAUD, 32'h3);
    rem_u.bit_clks = 48;
    apb(1, usbr_pkg::ADDR_TX_HOLD, 32'h96);
    wait_rx(3);
    chk(rem_u.rx_byte, 8'h96);
    repeat (60) @(posedge clk_sys);
    rem_u.bit_clks = 16;
    // Divisor zero freezes the frame in its start bit
    apb(1, usbr_pkg::ADDR_BAUD, 32'h0);
    rem_u.listen = 1'b0;
    apb(1, usbr_pkg::ADDR_TX_HOLD, 32'h11);
    repeat (300) @(posedge clk_sys);
    chk(serial_out_pin, 0);
    apb(1, usbr_pkg::ADDR_BAUD, 32'h1);
    repeat (250) @(posedge clk_sys);
    chk(serial_out_pin, 1);
    rem_u.listen = 1'b1;
    apb(1, usbr_pkg::ADDR_IRQ_EN, 32'h1);
    rem_u.send(8'h5a, 0, 1);
    repeat (20) @(posedge clk_sys);
    chk(irq, 1);
    rchk(usbr_pkg::ADDR_STATUS, 32'h203);
    rchk(usbr_pkg::ADDR_RX_HOLD, 32'h5a);
    rchk(usbr_pkg::ADDR_STATUS, 32'h202);
    rem_u.send(8'h11, 0, 1);
    rem_u.send(8'h66, 0, 1);
    repeat (20) @(posedge clk_sys);
    rchk(usbr_pkg::ADDR_RX_HOLD, 32'h66);
    rchk(usbr_pkg::ADDR_STATUS, 32'h222);
    rem_u.send(8'h77, 0, 0);
    repeat (20) @(posedge clk_sys);
    apb(0, usbr_pkg::ADDR_STATUS, 0);
    chk(rdat & 32'he0, 32'h60);
    rem_u.send(8'h0f, 1, 1);
    repeat (20) @(posedge clk_sys);
    apb(0, usbr_pkg::ADDR_STATUS, 0);
    chk(rdat & 32'he0, 32'he0);
    apb(1, usbr_pkg::ADDR_CONTROL, 32'h100);
    apb(0, usbr_pkg::ADDR_STATUS, 0);
    chk(rdat & 32'he0, 32'h0);
    apb(1, usbr_pkg::ADDR_MODE, 32'h8800);
    apb(1, usbr_pkg::ADDR_TX_HOLD, 32'hc3);
    repeat (200) @(posedge clk_sys);
    rchk(usbr_pkg::ADDR_RX_HOLD, 32'hc3);
    wrap_up();
  end
endmodule
